// ==== design/vlimit_consts.svh ====
// Offsets, field positions and reset values of the limit and pin register bank
// Summary of operation
// - Writable source high/low limit bytes reset to FFh and 00h.
// - Every new source reading is compared against all its limits.
// - Source reading at or above high limit raises alert and over flag.
// - Source reading below low limit raises alert and under flag.
// - Writable critical limits: sense signed reset 7Fh, source reset FFh.
// - Reading at or above critical limit drives critical pin low, sets flag.
// - Critical stays until reading below limit minus 5-bit hysteresis, reset 0Ah.
// - Pin configuration resets to 08h: input, change alert masked.
// - Unmasked input pin change raises alert; mask ignored for output.
// - Input bit mirrors pin; change while input sets pin status.
// - Output-level bit drives pin when output, reset 0.
// - Direction bit: 0 input (reset), 1 output.
// - Feature register shows straps captured at power-up, zero without straps.
// - Upper nibble is threshold strap, also peak threshold reset value.
// - Lower nibble is duration strap, also peak duration reset value.
// - Read-only part identification byte.
// - Read-only maker identification byte.
// - Read-only die revision byte.
`ifndef VLIMIT_CONSTS_SVH
`define VLIMIT_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_SRC_HIGH     8'h64
`define IDX_SRC_LOW      8'h65
`define IDX_SENSE_CRIT   8'h66
`define IDX_SRC_CRIT     8'h68
`define IDX_SENSE_HYST   8'h69
`define IDX_SRC_HYST     8'h6a
`define IDX_PIN_CFG      8'h70
`define IDX_STATUS       8'h71
`define IDX_PEAK_CTRL    8'h72
`define IDX_FEATURES     8'hfc
`define IDX_PART_ID      8'hfd
`define IDX_MAKER_ID     8'hfe
`define IDX_REVISION     8'hff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SRC_HIGH     8'hff
`define RST_SRC_LOW      8'h00
`define RST_SENSE_CRIT   8'h7f
`define RST_SRC_CRIT     8'hff
`define RST_HYST         5'h0a
`define RST_PIN_CFG      4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HYST_W           5
`define ST_OVER          0
`define ST_UNDER         1
`define ST_SENSE_CRIT    2
`define ST_SRC_CRIT      3
`define ST_PIN_CHANGE    4
`define ST_PIN_ALERT     5
`define ST_W             6
`define CH_SENSE         0
`define CH_SRC           1

`endif

// ==== design/vlimit_pkg.sv ====
// Types shared by the limit and pin register bank
package vlimit_pkg;

  // ----------------------------------------------------------------
  // Avalon-MM request from the master
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

  // ----------------------------------------------------------------
  // Pin configuration byte, low nibble
  // ----------------------------------------------------------------
  typedef struct packed {
    logic changeMask;
    logic inLevel;
    logic outLevel;
    logic dir;
  } pin_cfg_t;

  // ----------------------------------------------------------------
  // Bus answer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage : vlimit_pkg

// ==== design/voltage_limit_gpio_regs.sv ====
// Limit registers, critical alarm, general pin and identity registers
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vlimit_consts.svh"

module voltage_limit_gpio_regs #(
  parameter logic [7:0] PART_ID        = 8'h11, // Arbitrary value
  parameter logic [7:0] MAKER_ID       = 8'h22, // Arbitrary value
  parameter logic [7:0] REVISION_ID    = 8'h01, // Arbitrary value
  parameter bit         STRAPS_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Avalon-MM slave
  input  wire vlimit_pkg::avmm_req_t   busReq,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  // Measurements
  input  wire logic [7:0]              shuntReading,
  input  wire logic                    shuntValid,
  input  wire logic [7:0]              supplyReading,
  input  wire logic                    supplyValid,
  // Strap pins
  input  wire logic [3:0]              strapThresholdCode,
  input  wire logic [3:0]              strapDurationCode,
  // General-purpose pin
  input  wire logic                    pinIn,
  output logic                         pinOut,
  output logic                         pinOe,
  // Alarms and peak detector controls
  output logic                         alertN,
  output logic                         criticalAlarmN,
  output logic [3:0]                   peakThresholdField,
  output logic [3:0]                   peakDurationField
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vlimit_pkg::bus_state_t busState;
  vlimit_pkg::pin_cfg_t   pinCfg;
  logic [7:0]             srcHigh;
  logic [7:0]             srcLow;
  logic [7:0]             senseCrit;
  logic [7:0]             srcCrit;
  logic [4:0]             senseHyst;
  logic [4:0]             srcHyst;
  logic [`ST_W-1:0]       status;
  logic [`ST_W-1:0]       statusSet;
  logic [`ST_W-1:0]       statusClr;
  logic [7:0]             strapFeatures;
  logic                   strapsCaptured;
  logic                   pinSync1;
  logic                   pinSync2;
  logic                   pinPrev;
  logic                   pinChange;
  logic [2:0]             pinArm;
  logic                   cfgMask;
  logic                   cfgOut;
  logic                   cfgDir;
  logic                   wrPinCfg;
  logic                   wrStatus;
  logic                   wrPeak;
  logic                   busReqOn;
  logic                   accept;
  logic                   wrLane;
  logic [1:0]             critValid;
  logic [1:0]             critActive;
  logic [1:0]             critSet;
  logic [7:0]             critReading [2];
  logic [7:0]             critLimit   [2];
  logic [4:0]             critHyst    [2];

  // Index match, used by write strobes and the read mux
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    hit = (addr == idx);
  endfunction : hit

  // Widen a byte for the critical compare; only the sense channel is signed
  function automatic logic signed [9:0] widen(input logic [7:0] val, input logic isSigned);
    widen = isSigned ? {{2{val[7]}}, val} : {2'b00, val};
  endfunction : widen

  // Pin configuration reset pattern, taken apart into its stored bits
  localparam logic [3:0] PIN_CFG_RESET = `RST_PIN_CFG;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ----------------------------------------------------------------
  // The wait state buys a registered read path: the mux is sampled on
  // the request edge and its byte stands at the answer edge
  assign busReqOn    = busReq.read | busReq.write;
  assign accept      = busReqOn & (busState == vlimit_pkg::BUS_ACK);
  assign waitrequest = busReqOn & (busState != vlimit_pkg::BUS_ACK);
  assign wrLane      = busReq.write & accept & busReq.byteenable[0];

  // Strobes for the registers that live outside the limit bank
  assign wrPinCfg    = wrLane & hit(busReq.address, `IDX_PIN_CFG);
  assign wrStatus    = wrLane & hit(busReq.address, `IDX_STATUS);
  assign wrPeak      = wrLane & hit(busReq.address, `IDX_PEAK_CTRL);

  // Answer state: request seen, then released at the next edge
  // A request still held after its answer edge counts as a new one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busState <= vlimit_pkg::BUS_IDLE;
    else
    begin
      case (busState)
        vlimit_pkg::BUS_IDLE:
        begin
          if (busReqOn)
            busState <= vlimit_pkg::BUS_ACK;
        end
        vlimit_pkg::BUS_ACK:
          busState <= vlimit_pkg::BUS_IDLE;
        default:
          busState <= vlimit_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read data captured a cycle early so it is stable at the answer edge
  // Unmapped indices read as zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0;
    else if (busReq.read && busState == vlimit_pkg::BUS_IDLE)
    begin
      readdata <= 32'h0;
      if (hit(busReq.address, `IDX_SRC_HIGH))
        readdata[7:0] <= srcHigh;
      else if (hit(busReq.address, `IDX_SRC_LOW))
        readdata[7:0] <= srcLow;
      else if (hit(busReq.address, `IDX_SENSE_CRIT))
        readdata[7:0] <= senseCrit;
      else if (hit(busReq.address, `IDX_SRC_CRIT))
        readdata[7:0] <= srcCrit;
      else if (hit(busReq.address, `IDX_SENSE_HYST))
        readdata[4:0] <= senseHyst;
      else if (hit(busReq.address, `IDX_SRC_HYST))
        readdata[4:0] <= srcHyst;
      else if (hit(busReq.address, `IDX_PIN_CFG))
        readdata[3:0] <= pinCfg;
      else if (hit(busReq.address, `IDX_STATUS))
        readdata[`ST_W-1:0] <= status;
      else if (hit(busReq.address, `IDX_PEAK_CTRL))
        readdata[7:0] <= {peakThresholdField, peakDurationField};
      else if (hit(busReq.address, `IDX_FEATURES))
        readdata[7:0] <= strapFeatures;
      else if (hit(busReq.address, `IDX_PART_ID))
        readdata[7:0] <= PART_ID;
      else if (hit(busReq.address, `IDX_MAKER_ID))
        readdata[7:0] <= MAKER_ID;
      else if (hit(busReq.address, `IDX_REVISION))
        readdata[7:0] <= REVISION_ID;
    end
  end

  // ----------------------------------------------------------------
  // Limit and hysteresis registers
  // ----------------------------------------------------------------
  // A reading in the same cycle as a limit write meets the old limit
  // Read-only indices have no write strobe at all
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srcHigh   <= `RST_SRC_HIGH;
      srcLow    <= `RST_SRC_LOW;
      senseCrit <= `RST_SENSE_CRIT;
      srcCrit   <= `RST_SRC_CRIT;
      senseHyst <= `RST_HYST;
      srcHyst   <= `RST_HYST;
    end
    else if (wrLane)
    begin
      if (hit(busReq.address, `IDX_SRC_HIGH))
        srcHigh <= busReq.writedata[7:0];
      if (hit(busReq.address, `IDX_SRC_LOW))
        srcLow <= busReq.writedata[7:0];
      if (hit(busReq.address, `IDX_SENSE_CRIT))
        senseCrit <= busReq.writedata[7:0];
      if (hit(busReq.address, `IDX_SRC_CRIT))
        srcCrit <= busReq.writedata[7:0];
      if (hit(busReq.address, `IDX_SENSE_HYST))
        senseHyst <= busReq.writedata[4:0];
      if (hit(busReq.address, `IDX_SRC_HYST))
        srcHyst <= busReq.writedata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Critical channels: sense is signed, source is unsigned
  // ----------------------------------------------------------------
  // Between readings the alarm only holds; a release needs a fresh
  // reading below limit minus hysteresis
  assign critValid      = {supplyValid, shuntValid};
  assign critReading[0] = shuntReading;
  assign critReading[1] = supplyReading;
  assign critLimit[0]   = senseCrit;
  assign critLimit[1]   = srcCrit;
  assign critHyst[0]    = senseHyst;
  assign critHyst[1]    = srcHyst;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_crit
    logic signed [9:0] valueExt;
    logic signed [9:0] limitExt;
    logic signed [9:0] releaseLevel;
    logic              atLimit;
    logic              belowRelease;

    // Ten bits leave room for a negative release level
    assign valueExt = widen(critReading[ch], ch == `CH_SENSE);
    assign limitExt = widen(critLimit[ch], ch == `CH_SENSE);
    assign releaseLevel = limitExt - $signed({5'h00, critHyst[ch]});
    assign atLimit      = valueExt >= limitExt;
    assign belowRelease = valueExt < releaseLevel;
    assign critSet[ch]  = critValid[ch] & atLimit;

    // Alarm holds through the hysteresis band
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        critActive[ch] <= 1'b0;
      else if (critValid[ch])
      begin
        if (atLimit)
          critActive[ch] <= 1'b1;
        else if (belowRelease)
          critActive[ch] <= 1'b0;
      end
    end
  end

  assign criticalAlarmN = ~|critActive;

  // ----------------------------------------------------------------
  // General-purpose pin
  // ----------------------------------------------------------------
  // Two stages before any logic looks at the pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      pinPrev  <= 1'b0;
    end
    else
    begin
      pinSync1 <= pinIn;
      pinSync2 <= pinSync1;
      pinPrev  <= pinSync2;
    end
  end

  // Change detection waits until the history holds real pin samples,
  // else a pin idling high would show a false edge after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pinArm <= 3'b000;
    else
      pinArm <= {pinArm[1:0], 1'b1};
  end

  // Output drive ignores the pin input, so only inputs report change
  assign pinChange = pinArm[2] & ~cfgDir & (pinSync2 ^ pinPrev);

  // Stored configuration bits; a write to the level bit is dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfgMask <= PIN_CFG_RESET[3];
      cfgOut  <= PIN_CFG_RESET[1];
      cfgDir  <= PIN_CFG_RESET[0];
    end
    else if (wrPinCfg)
    begin
      cfgMask <= busReq.writedata[3];
      cfgOut  <= busReq.writedata[1];
      cfgDir  <= busReq.writedata[0];
    end
  end

  // Readback view; the level bit is only ever the synchronised pin
  assign pinCfg.changeMask = cfgMask;
  assign pinCfg.inLevel    = pinSync2;
  assign pinCfg.outLevel   = cfgOut;
  assign pinCfg.dir        = cfgDir;
  assign pinOe             = cfgDir;
  assign pinOut            = cfgOut;

  // ----------------------------------------------------------------
  // Sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb
  begin
    statusSet = '0;
    statusSet[`ST_OVER]       = supplyValid & (supplyReading >= srcHigh);
    statusSet[`ST_UNDER]      = supplyValid & (supplyReading < srcLow);
    statusSet[`ST_SENSE_CRIT] = critSet[`CH_SENSE];
    statusSet[`ST_SRC_CRIT]   = critSet[`CH_SRC];
    statusSet[`ST_PIN_CHANGE] = pinChange;
    statusSet[`ST_PIN_ALERT]  = pinChange & ~pinCfg.changeMask;
  end

  // Write one to clear; a cause present in the same cycle wins
  assign statusClr = wrStatus ? busReq.writedata[`ST_W-1:0] : '0;

  // Flags stay until cleared, so a short excursion is never lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status <= '0;
    else
      status <= (status & ~statusClr) | statusSet;
  end

  // Alert stays low until software clears every cause
  // Critical causes are left out: they have a pin of their own
  assign alertN = ~(status[`ST_OVER] | status[`ST_UNDER] | status[`ST_PIN_ALERT]);

  // ----------------------------------------------------------------
  // Straps and peak detector control
  // ----------------------------------------------------------------
  // Straps sampled on the first edge after reset, never under reset
  // Later strap movement is ignored until the next reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strapsCaptured <= 1'b0;
      strapFeatures  <= 8'h00;
    end
    else if (!strapsCaptured)
    begin
      strapsCaptured <= 1'b1;
      if (STRAPS_PRESENT)
        strapFeatures <= {strapThresholdCode, strapDurationCode};
    end
  end

  // Peak fields start from the straps and are writable afterwards
  // Only the first edge loads straps; no write can arrive that early
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      peakThresholdField <= 4'h0;
      peakDurationField  <= 4'h0;
    end
    else if (!strapsCaptured)
    begin
      peakThresholdField <= STRAPS_PRESENT ? strapThresholdCode : 4'h0;
      peakDurationField  <= STRAPS_PRESENT ? strapDurationCode : 4'h0;
    end
    else if (wrPeak)
    begin
      peakThresholdField <= busReq.writedata[7:4];
      peakDurationField  <= busReq.writedata[3:0];
    end
  end

endmodule : voltage_limit_gpio_regs
`default_nettype wire

// ==== sim/voltage_limit_gpio_regs_properties.sv ====
// Checker for the limit and pin register bank
`timescale 1ns/1ps
`default_nettype none
module voltage_limit_gpio_regs_checker #(
  parameter logic [7:0] PART_ID     = 8'h11,
  parameter logic [7:0] MAKER_ID    = 8'h22,
  parameter logic [7:0] REVISION_ID = 8'h01
) (
  // Clock, reset and bus
  input wire logic                  clk,
  input wire logic                  rst,
  input wire vlimit_pkg::avmm_req_t busReq,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  // Measurements, pin and alarms
  input wire logic [7:0]            supplyReading,
  input wire logic                  supplyValid,
  input wire logic                  shuntValid,
  input wire logic                  pinIn,
  input wire logic                  pinOut,
  input wire logic                  pinOe,
  input wire logic                  alertN,
  input wire logic                  criticalAlarmN
);
  logic [7:0] hi;
  logic [7:0] lo;
  logic [7:0] crit;
  logic [3:0] cfg;
  logic       wr;
  logic       rdDone;

  // Accepted bus cycles
  assign wr = busReq.write && !waitrequest && busReq.byteenable[0];
  assign rdDone = busReq.read && !waitrequest;

  // Shadow of writable settings; the checker sees no register contents
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hi <= 8'hff;
      lo <= 8'h00;
      crit <= 8'hff;
      cfg <= 4'h8;
    end
    else if (wr)
    begin
      if (busReq.address == 8'h64) hi <= busReq.writedata[7:0];
      if (busReq.address == 8'h65) lo <= busReq.writedata[7:0];
      if (busReq.address == 8'h68) crit <= busReq.writedata[7:0];
      if (busReq.address == 8'h70) cfg <= busReq.writedata[3:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----
  // Properties
  // ----
  property p_over;
    supplyValid && supplyReading >= hi |=> !alertN;
  endproperty
  a_over: assert property (p_over) else $error("over limit gave no alert");
  property p_under;
    supplyValid && supplyReading < lo |=> !alertN;
  endproperty
  a_under: assert property (p_under) else $error("under limit gave no alert");
  property p_critSet;
    supplyValid && supplyReading >= crit |=> !criticalAlarmN;
  endproperty
  a_critSet: assert property (p_critSet) else $error("critical not raised");
  property p_critHold;
    !criticalAlarmN && !supplyValid && !shuntValid |=> !criticalAlarmN;
  endproperty
  a_critHold: assert property (p_critHold) else $error("critical dropped alone");
  property p_critRel;
    $rose(criticalAlarmN) |-> $past(supplyValid || shuntValid);
  endproperty
  a_critRel: assert property (p_critRel) else $error("critical released idle");
  property p_pinDrive;
    pinOe == cfg[0] && (!cfg[0] || pinOut == cfg[1]);
  endproperty
  a_pinDrive: assert property (p_pinDrive) else $error("pin drive wrong");
  property p_pinChange;
    !pinOe && !cfg[3] && $changed(pinIn) |-> ##[1:5] !alertN;
  endproperty
  a_pinChange: assert property (p_pinChange) else $error("pin change no alert");
  property p_limits;
    rdDone && busReq.address[7:1] == 7'h32 |-> readdata[7:0] == (busReq.address[0] ? lo : hi);
  endproperty
  a_limits: assert property (p_limits) else $error("limit read wrong");
  property p_ids;
    rdDone && busReq.address >= 8'hfd |-> readdata[7:0] == (busReq.address == 8'hfd ? PART_ID
      : busReq.address == 8'hfe ? MAKER_ID : REVISION_ID);
  endproperty
  a_ids: assert property (p_ids) else $error("identity read wrong");
endmodule : voltage_limit_gpio_regs_checker

bind voltage_limit_gpio_regs voltage_limit_gpio_regs_checker #(
  .PART_ID(PART_ID), .MAKER_ID(MAKER_ID), .REVISION_ID(REVISION_ID)
) u_chk (
  .clk(clk), .rst(rst), .busReq(busReq), .readdata(readdata), .waitrequest(waitrequest),
  .supplyReading(supplyReading), .supplyValid(supplyValid), .shuntValid(shuntValid),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .alertN(alertN),
  .criticalAlarmN(criticalAlarmN)
);
`default_nettype wire

// ==== sim/pin_board_model.sv ====
// Board model of the general pin: pull-up and an external driver
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  // Device side
  input wire logic  pinOut,
  input wire logic  pinOe,
  // Board side
  input wire logic  extEn,
  input wire logic  extLevel,
  output logic      pinLevel
);
  // Device drive wins, then the external driver; a pin driven by neither floats up to the pull-up
  assign pinLevel = pinOe ? pinOut : (extEn ? extLevel : 1'b1);
endmodule : pin_board_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench of the limit and pin register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] PID = 8'h4c; // Arbitrary value
  localparam logic [7:0] MID = 8'h93; // Arbitrary value
  localparam logic [7:0] RID = 8'h07; // Arbitrary value
  localparam logic [3:0] THR = 4'h5;
  localparam logic [3:0] DUR = 4'hc;
  localparam logic [7:0] RA [12] = '{8'h64, 8'h65, 8'h66, 8'h68, 8'h69, 8'h6a, 8'h70, 8'hfc,
                                     8'hfd, 8'hfe, 8'hff, 8'h10};
  localparam logic [7:0] RE [12] = '{8'hff, 8'h00, 8'h7f, 8'hff, 8'h0a, 8'h0a, 8'h08,
                                     {THR, DUR}, PID, MID, RID, 8'h00};
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  vlimit_pkg::avmm_req_t busReq = '0;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic [7:0]            shuntReading = 8'h00;
  logic [7:0]            supplyReading = 8'h00;
  logic                  shuntValid = 1'b0;
  logic                  supplyValid = 1'b0;
  logic                  pinIn, pinOut, pinOe, alertN, criticalAlarmN;
  logic                  extLevel = 1'b0;
  logic [3:0]            peakThresholdField, peakDurationField;
  logic [31:0]           expQ[$];
  string                 nameQ[$];
  logic [7:0]            v;
  int                    error_cnt = 0;
  int                    n_checks = 0;

  always #2.5 clk = ~clk;

  voltage_limit_gpio_regs #(.PART_ID(PID), .MAKER_ID(MID), .REVISION_ID(RID))
  u_voltage_limit_gpio_regs (
    .clk(clk), .rst(rst), .busReq(busReq), .readdata(readdata), .waitrequest(waitrequest),
    .shuntReading(shuntReading), .shuntValid(shuntValid), .supplyReading(supplyReading),
    .supplyValid(supplyValid), .strapThresholdCode(THR), .strapDurationCode(DUR),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .alertN(alertN),
    .criticalAlarmN(criticalAlarmN), .peakThresholdField(peakThresholdField),
    .peakDurationField(peakDurationField));
  pin_board_model u_pin_board_model (.pinOut(pinOut), .pinOe(pinOe), .extEn(1'b1),
    .extLevel(extLevel), .pinLevel(pinIn));

  // ----
  // Tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{rd, !rd, a, {24'h0, d}, 4'h1};
    do @(posedge clk); while (waitrequest !== 1'b0);
    busReq <= '0;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    nameQ.push_back($sformatf("reg %h", a));
    acc(1'b1, a, 8'h00);
  endtask : rd

  // One measurement pulse, then a cycle for the alarms to settle
  task automatic cm(input logic sup, input logic [7:0] x, input logic e);
    @(posedge clk);
    supplyReading <= sup ? x : supplyReading;
    shuntReading <= sup ? shuntReading : x;
    supplyValid <= sup;
    shuntValid <= !sup;
    @(posedge clk);
    supplyValid <= 1'b0;
    shuntValid <= 1'b0;
    @(posedge clk);
    chk("criticalAlarmN", {31'h0, e}, {31'h0, criticalAlarmN});
  endtask : cm

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Read answers compared against the oldest note
  always @(posedge clk)
    if (busReq.read && waitrequest === 1'b0)
      chk(nameQ.pop_front(), expQ.pop_front(), readdata);

  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    void'($urandom(32'h0cbb4226));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (RA[i]) rd(RA[i], RE[i]);
    chk("peakThr", {28'h0, THR}, {28'h0, peakThresholdField});
    chk("peakDur", {28'h0, DUR}, {28'h0, peakDurationField});
    acc(1'b0, 8'h72, 8'h3a);
    rd(8'h72, 8'h3a);
    chk("peakFields", 32'h3a, {24'h0, peakThresholdField, peakDurationField});
    // Random limits read back; hysteresis keeps five bits
    repeat (4)
    begin
      v = 8'($urandom);
      acc(1'b0, 8'h64, v);
      rd(8'h64, v);
      acc(1'b0, 8'h69, v);
      rd(8'h69, {3'h0, v[4:0]});
    end
    acc(1'b0, 8'h69, 8'h0a);
    acc(1'b0, 8'hfd, 8'hff);
    acc(1'b0, 8'h10, 8'h55);
    rd(8'hfd, PID);
    rd(8'h10, 8'h00);
    // Source limits at both boundaries, status cleared after each
    acc(1'b0, 8'h64, 8'h80);
    acc(1'b0, 8'h65, 8'h20);
    foreach (RE[i])
      if (i < 4)
      begin
        v = i == 0 ? 8'h80 : i == 1 ? 8'h7f : i == 2 ? 8'h20 : 8'h1f;
        cm(1'b1, v, 1'b1);
        rd(8'h71, i == 0 ? 8'h01 : i == 3 ? 8'h02 : 8'h00);
        chk("alertN", {31'h0, i == 1 || i == 2}, {31'h0, alertN});
        acc(1'b0, 8'h71, 8'h3f);
      end
    // Critical set, held inside hysteresis, released below it: source just below, sense at a negative reading
    acc(1'b0, 8'h64, 8'hff);
    acc(1'b0, 8'h68, 8'hc0);
    acc(1'b0, 8'h66, 8'h10);
    cm(1'b1, 8'hc0, 1'b0);
    cm(1'b1, 8'hb6, 1'b0);
    cm(1'b1, 8'hb5, 1'b1);
    cm(1'b0, 8'h10, 1'b0);
    cm(1'b0, 8'h07, 1'b0);
    cm(1'b0, 8'hf0, 1'b1);
    rd(8'h71, 8'h0c);
    acc(1'b0, 8'h71, 8'h3f);
    // Pin as output, then as input with and without the mask
    extLevel <= 1'b1;
    acc(1'b0, 8'h70, 8'h0b);
    repeat (5) @(posedge clk);
    chk("pinOe", 32'h1, {31'h0, pinOe});
    rd(8'h70, 8'h0f);
    acc(1'b0, 8'h70, 8'h00);
    acc(1'b0, 8'h71, 8'h3f);
    extLevel <= 1'b0;
    repeat (6) @(posedge clk);
    chk("alertN", 32'h0, {31'h0, alertN});
    rd(8'h71, 8'h30);
    acc(1'b0, 8'h71, 8'h3f);
    acc(1'b0, 8'h70, 8'h0a);
    extLevel <= 1'b1;
    repeat (6) @(posedge clk);
    chk("alertN", 32'h1, {31'h0, alertN});
    rd(8'h71, 8'h10);
    rd(8'h70, 8'h0e);
    final_report();
  end
endmodule : testbench
`default_nettype wire
